// ===== rtl/ptc_pkg.sv
// Package of register offsets, field layouts and reset values for the period timer control
package ptc_pkg;
   localparam logic [3:0] PTC_ADR_CTRL = 4'h0;
   localparam logic [3:0] PTC_ADR_COUNT = 4'h1;
   localparam logic [3:0] PTC_ADR_PERIOD = 4'h2;
   localparam logic [3:0] PTC_ADR_STATUS = 4'h3;
   localparam logic [3:0] PTC_ADR_MASK = 4'h4;
   localparam logic [3:0] PTC_ADR_MODE = 4'h5;
   localparam int PTC_RUN_BIT = 7;
   localparam int PTC_PRE_LSB = 4;
   localparam int PTC_POST_LSB = 0;
   localparam int PTC_EV_MATCH = 0;
   localparam int PTC_EV_POST = 1;
   localparam int PTC_EV_HWCLR = 2;
   localparam logic [7:0] PTC_CTRL_RST = 8'h00;
   localparam logic [7:0] PTC_COUNT_RST = 8'h00;
   localparam logic [7:0] PTC_PERIOD_RST = 8'hff;
   localparam logic [2:0] PTC_STAT_RST = 3'h0;
   localparam logic [6:0] PTC_PRE_RST = 7'h00;
   localparam logic [3:0] PTC_POST_RST = 4'h0;
endpackage

// ===== rtl/ptc_timer.sv
// Period timer with run bit, prescaler, postscaler and classic Wishbone registers
`timescale 1ns/1ps
// Notes on behaviour
// - Counting only while run is set; run clear holds counter and scalers in reset.
// - Prescaler divides timer clock by two to the power of the select code.
// - Postscale ratio is select field plus one, 1:1 to 1:16.
// - One postscaled event for every N period matches.
// - Hardware clears run bit on period match in one-shot mode.
// - When count equals working period, next prescaler rollover returns count to zero.
// - Working period reloads on count or control write, external reset, match rollover.
module ptc_timer (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic tick_i,
   input wire logic ext_reset_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic match_o,
   output logic post_event_o,
   output logic irq_o
);
   import ptc_pkg::*;

   logic [7:0] ctrl_r, ctrl_nxt;
   logic [7:0] count_value_r, count_value_nxt;
   logic [7:0] period_value_r, period_value_nxt;
   logic [7:0] work_period_r, work_period_nxt;
   logic [6:0] pre_cnt_r, pre_cnt_nxt;
   logic [3:0] post_cnt_r, post_cnt_nxt;
   logic [2:0] status_r, status_nxt;
   logic [2:0] mask_r, mask_nxt;
   logic one_shot_r, one_shot_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] rdat_r, rdat_nxt;
   logic match_r, match_nxt;
   logic post_r, post_nxt;

   logic req, wr, wr_lane0;
   logic run;
   logic [2:0] input_divide_select;
   logic [3:0] match_divide_select;
   logic pre_roll, at_period, ev_match, ev_post;
   logic [2:0] ev_vec;

   // Mask of prescaler bits that must all be one for a rollover
   function automatic logic [6:0] pre_mask(input logic [2:0] sel);
      pre_mask = 7'((8'h01 << sel) - 8'h01);
   endfunction

   function automatic logic hit(input logic [3:0] adr, input logic [3:0] reg_adr);
      hit = (adr == reg_adr);
   endfunction

   assign req = wb_cyc_i & wb_stb_i & ~ack_r;
   assign wr = req & wb_we_i;
   assign wr_lane0 = wr & wb_sel_i[0];
   assign run = ctrl_r[PTC_RUN_BIT];
   assign input_divide_select = ctrl_r[PTC_PRE_LSB +: 3];
   assign match_divide_select = ctrl_r[PTC_POST_LSB +: 4];

   // Prescaler counts raw ticks; its mask lets a select change apply without touching count
   assign pre_roll = run & tick_i & ((pre_cnt_r & pre_mask(input_divide_select))
                     == pre_mask(input_divide_select));
   assign at_period = (count_value_r == work_period_r);
   assign ev_match = pre_roll & at_period;
   assign ev_post = ev_match & (post_cnt_r == match_divide_select);

   always_comb begin
      ctrl_nxt = ctrl_r;
      count_value_nxt = count_value_r;
      period_value_nxt = period_value_r;
      work_period_nxt = work_period_r;
      pre_cnt_nxt = pre_cnt_r;
      post_cnt_nxt = post_cnt_r;
      one_shot_nxt = one_shot_r;
      match_nxt = 1'b0;
      post_nxt = 1'b0;
      if (!run) begin
         pre_cnt_nxt = PTC_PRE_RST;
         post_cnt_nxt = PTC_POST_RST;
         count_value_nxt = PTC_COUNT_RST;
      end else if (tick_i) begin
         // Run set by software is first seen here, on the next timer clock
         pre_cnt_nxt = pre_roll ? PTC_PRE_RST : 7'(pre_cnt_r + 7'h01);
         if (pre_roll) begin
            if (at_period) begin
               count_value_nxt = PTC_COUNT_RST;
               work_period_nxt = period_value_r;
               match_nxt = 1'b1;
               post_cnt_nxt = ev_post ? PTC_POST_RST : 4'(post_cnt_r + 4'h1);
               post_nxt = ev_post;
               if (one_shot_r) begin
                  ctrl_nxt[PTC_RUN_BIT] = 1'b0;
               end
            end else begin
               count_value_nxt = 8'(count_value_r + 8'h01);
            end
         end
      end
      if (ext_reset_i) begin
         count_value_nxt = PTC_COUNT_RST;
         work_period_nxt = period_value_r;
      end
      if (wr_lane0 && hit(wb_adr_i, PTC_ADR_CTRL)) begin
         ctrl_nxt = wb_dat_i[7:0];
         work_period_nxt = period_value_r;
      end
      if (wr_lane0 && hit(wb_adr_i, PTC_ADR_COUNT)) begin
         count_value_nxt = wb_dat_i[7:0];
         work_period_nxt = period_value_r;
      end
      if (wr_lane0 && hit(wb_adr_i, PTC_ADR_PERIOD)) begin
         period_value_nxt = wb_dat_i[7:0];
      end
      if (wr_lane0 && hit(wb_adr_i, PTC_ADR_MODE)) begin
         one_shot_nxt = wb_dat_i[0];
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_r <= PTC_CTRL_RST;
         count_value_r <= PTC_COUNT_RST;
         period_value_r <= PTC_PERIOD_RST;
         work_period_r <= PTC_PERIOD_RST;
         pre_cnt_r <= PTC_PRE_RST;
         post_cnt_r <= PTC_POST_RST;
         one_shot_r <= 1'b0;
         match_r <= 1'b0;
         post_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         count_value_r <= count_value_nxt;
         period_value_r <= period_value_nxt;
         work_period_r <= work_period_nxt;
         pre_cnt_r <= pre_cnt_nxt;
         post_cnt_r <= post_cnt_nxt;
         one_shot_r <= one_shot_nxt;
         match_r <= match_nxt;
         post_r <= post_nxt;
      end
   end

   // Interrupt status: a new event wins over a write-one clear in the same cycle
   assign ev_vec = {ev_match & one_shot_r & run, ev_post, ev_match};

   always_comb begin
      status_nxt = status_r;
      mask_nxt = mask_r;
      if (wr_lane0 && hit(wb_adr_i, PTC_ADR_STATUS)) begin
         status_nxt = status_r & ~wb_dat_i[2:0];
      end
      if (wr_lane0 && hit(wb_adr_i, PTC_ADR_MASK)) begin
         mask_nxt = wb_dat_i[2:0];
      end
      status_nxt = status_nxt | ev_vec;
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         status_r <= PTC_STAT_RST;
         mask_r <= PTC_STAT_RST;
      end else begin
         status_r <= status_nxt;
         mask_r <= mask_nxt;
      end
   end

   // Bus slave: one wait state, ack for exactly one cycle; unmapped reads return zero
   always_comb begin
      ack_nxt = req;
      rdat_nxt = rdat_r;
      if (req && !wb_we_i) begin
         unique case (wb_adr_i)
            PTC_ADR_CTRL: rdat_nxt = {24'h0, ctrl_r};
            PTC_ADR_COUNT: rdat_nxt = {24'h0, count_value_r};
            PTC_ADR_PERIOD: rdat_nxt = {24'h0, period_value_r};
            PTC_ADR_STATUS: rdat_nxt = {29'h0, status_r};
            PTC_ADR_MASK: rdat_nxt = {29'h0, mask_r};
            PTC_ADR_MODE: rdat_nxt = {31'h0, one_shot_r};
            default: rdat_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_r <= 1'b0;
         rdat_r <= 32'h0;
      end else begin
         ack_r <= ack_nxt;
         rdat_r <= rdat_nxt;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;
   assign match_o = match_r;
   assign post_event_o = post_r;
   assign irq_o = |(status_r & mask_r);
endmodule // ptc_timer

// ===== test/ptc_chk.sv
// Checker of bus handshake, timer pulses and interrupt timing at the timer ports
`timescale 1ns/1ps
module ptc_chk (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic tick_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic match_o,
   input wire logic post_event_o,
   input wire logic irq_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack held");
   property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
   property p_dat_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
   a_dat_upper: assert property (p_dat_upper) else $error("upper bits set");
   property p_match_tick; match_o |-> $past(tick_i); endproperty
   a_match_tick: assert property (p_match_tick) else $error("match w/o tick");
   property p_post_tick; post_event_o |-> $past(tick_i); endproperty
   a_post_tick: assert property (p_post_tick) else $error("post w/o tick");
   property p_irq_fall; $fell(irq_o) |-> wb_we_i && wb_ack_o; endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
   property p_irq_rise; $rose(irq_o) |-> $past(wb_we_i) || match_o || $past(match_o); endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq rose alone");
   c_match: cover property (match_o);
   c_post: cover property (post_event_o);
   c_irq: cover property ($rose(irq_o));
endmodule // ptc_chk
bind ptc_timer ptc_chk ptc_chk_inst (.clock_i(clock_i), .rstn_i(rstn_i), .tick_i(tick_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .match_o(match_o), .post_event_o(post_event_o), .irq_o(irq_o));

// ===== test/ptc_timer_tb.sv
// Self-checking bench for the period timer registers, scalers and interrupt
`timescale 1ns/1ps
module ptc_timer_tb;
   import ptc_pkg::*;
   logic clock_i = 0, rstn_i = 0, tick_i = 1, ext_reset_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
   logic wb_we_i = 0, wb_ack_o, match_o, post_event_o, irq_o;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   int fail_count = 0, n_checks = 0;
   ptc_timer ptc_timer_inst (.clock_i(clock_i), .rstn_i(rstn_i), .tick_i(tick_i),
      .ext_reset_i(ext_reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .match_o(match_o), .post_event_o(post_event_o), .irq_o(irq_o));
   initial begin
      forever #12.5 clock_i = ~clock_i;
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic [3:0] a, input logic we, input logic [7:0] d);
      @(posedge clock_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      for (int i = 0; wb_ack_o !== 1'b1; i++) begin
         if (i == 50) begin
            fail_count++;
            finish_test();
         end
         @(posedge clock_i);
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      bus(a, 1'b0, 8'h00);
      chk(q, {24'h0, e});
   endtask
   // Skips the first event, whose spacing a reconfiguration may have disturbed
   task automatic gap(input logic post, input int e);
      int n;
      n = 0;
      while ((post ? post_event_o : match_o) !== 1'b1 && n < 3000) begin
         @(negedge clock_i);
         n++;
      end
      if (n >= 3000) fail_count++;
      n = 0;
      do begin
         @(negedge clock_i);
         n++;
      end while ((post ? post_event_o : match_o) !== 1'b1 && n < 3000);
      chk(n, e);
   endtask
   initial begin
      repeat (3) @(posedge clock_i);
      rstn_i <= 1'b1;
      for (int a = 0; a < 7; a++) rd(a[3:0], (a == 2) ? 8'hff : 8'h00);
      bus(4'h6, 1'b1, 8'hff);
      rd(4'h6, 8'h00);
      $display("test reset done");
      bus(PTC_ADR_PERIOD, 1'b1, 8'h01);
      for (int s = 0; s < 8; s++) begin
         bus(PTC_ADR_CTRL, 1'b1, {1'b1, s[2:0], 4'h0});
         gap(1'b0, 2 << s);
      end
      $display("test prescale done");
      bus(PTC_ADR_PERIOD, 1'b1, 8'h00);
      for (int c = 0; c < 16; c++) begin
         bus(PTC_ADR_CTRL, 1'b1, {4'h8, c[3:0]});
         gap(1'b1, c + 1);
      end
      $display("test postscale done");
      bus(PTC_ADR_CTRL, 1'b1, 8'h00);
      bus(PTC_ADR_STATUS, 1'b1, 8'h07);
      bus(PTC_ADR_PERIOD, 1'b1, 8'h03);
      bus(PTC_ADR_MODE, 1'b1, 8'h01);
      bus(PTC_ADR_CTRL, 1'b1, 8'h80);
      for (int n = 0; match_o !== 1'b1 && n < 100; n++) @(negedge clock_i);
      if (match_o !== 1'b1) fail_count++;
      rd(PTC_ADR_CTRL, 8'h00);
      rd(PTC_ADR_STATUS, 8'h07);
      bus(PTC_ADR_COUNT, 1'b1, 8'h05);
      rd(PTC_ADR_COUNT, 8'h00);
      @(negedge clock_i);
      chk({31'h0, irq_o}, 32'h0);
      bus(PTC_ADR_MASK, 1'b1, 8'h04);
      @(negedge clock_i);
      chk({31'h0, irq_o}, 32'h1);
      bus(PTC_ADR_STATUS, 1'b1, 8'h04);
      @(negedge clock_i);
      chk({31'h0, irq_o}, 32'h0);
      rd(PTC_ADR_STATUS, 8'h03);
      $display("test one-shot done");
      bus(PTC_ADR_MODE, 1'b1, 8'h00);
      wb_sel_i <= 4'he;
      bus(PTC_ADR_MASK, 1'b1, 8'h00);
      wb_sel_i <= 4'hf;
      rd(PTC_ADR_MASK, 8'h04);
      ext_reset_i <= 1'b1;
      bus(PTC_ADR_CTRL, 1'b1, 8'h80);
      bus(PTC_ADR_PERIOD, 1'b1, 8'h02);
      rd(PTC_ADR_COUNT, 8'h00);
      ext_reset_i <= 1'b0;
      gap(1'b0, 3);
      $display("test external reset done");
      finish_test();
   end
endmodule // ptc_timer_tb
